// ---- bbagc_config_regs.sv ----
// Receive gain configuration register bank with AXI4-Lite access
// Operation
// - CW scale zero forces on, sevens off
// - Inner lock window from five-bit field
// - Antenna search only within max lock count
// - Outer window positive side five bits
// - Six-bit backoff sets converter headroom
// - Read select picks table entry or data
// - Table entries are seven-bit unsigned
// - Seven-bit fractional loop coefficient applied
// - Override RF bit one removes pad
// - Override IF value replaces loop output
// - Continuous bit allows updates during freeze
// - Polarity bit inverts RF step output
// - Extra refinement unless disable bit set
// - Override bit drives both RF, IF
// - Abort second antenna search on weaker power
// - Sat step only when control bit set
// - Pad removed below voltage threshold
// - Mid twice value, low direct, on counts
// - Sat step suppressed at block level
// - Negative window magnitude negated internally
// - Six-bit second carrier sense scale
// - TX power latched on enable rise
`timescale 1ns/1ns
module bbagc_config_regs
    import bbagc_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite slave
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [DATA_W-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Gain loop status, same clock
    input wire logic [7:0] agc_updates_to_lock,
    input wire logic agc_freeze,
    input wire logic agc_locked,
    input wire logic second_ant_power_lower,
    input wire logic [6:0] agc_voltage,
    input wire logic loop_rf_pad_remove,
    input wire logic [6:0] loop_if_gain,
    input wire logic [5:0] agc_level_halfdb,
    input wire logic [3:0] iq_sat_count,
    input wire logic [3:0] mid_sat_threshold,
    input wire logic [3:0] low_sat_threshold,
    // Transmit path enable pin, asynchronous
    input wire logic transmit_path_enable,
    // Decoded controls to the gain loop
    output logic [2:0] cw_scale,
    output logic cw_force_active,
    output logic cw_force_inactive,
    output logic [4:0] inner_lock_window,
    output logic antenna_search_allow,
    output logic [4:0] outer_window_pos,
    output logic signed [5:0] outer_window_neg,
    output logic [5:0] adc_backoff,
    output logic [6:0] loop_coefficient,
    output logic gain_update_allow,
    output logic extra_update_enable,
    output logic abort_second_antenna,
    output logic [4:0] sat_atten_mid,
    output logic [3:0] sat_atten_low,
    output logic [5:0] second_carrier_sense,
    output logic rf_gain_step_line,
    output logic [6:0] if_gain_line,
    output logic signed [6:0] tx_power_dac
);
    // ------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------
    logic [7:0] regs_q [NUM_REGS];
    logic [6:0] table_q [TABLE_DEPTH];
    bbagc_wr_state_t wr_state_q, wr_state_d;
    logic [ADDR_W-1:0] awaddr_q;
    logic [7:0] wdata_q;
    logic wstrb0_q;
    logic [1:0] bresp_q;
    logic rvalid_q;
    logic [DATA_W-1:0] rdata_q;
    logic [1:0] rresp_q;
    logic transmit_path_enable_meta_q, transmit_path_enable_sync_q, transmit_path_enable_prev_q;
    logic signed [6:0] tx_power_q;
    logic [2:0] cw_scale_q;
    logic cw_on_q, cw_off_q;
    logic [4:0] inner_q, outer_pos_q;
    logic signed [5:0] outer_neg_q;
    logic [5:0] backoff_q, cs2_q;
    logic [6:0] coef_q, if_gain_q;
    logic search_q, upd_q, extra_q, abort_q, rf_q;
    logic [4:0] mid_q;
    logic [3:0] low_q;

    // ------------------------------------------------------------------
    // Write channel
    // ------------------------------------------------------------------
    wire aw_take = s_axi_awvalid && s_axi_awready;
    wire w_take = s_axi_wvalid && s_axi_wready;
    wire wr_commit = (wr_state_d == BBAGC_WR_RESP) &&
        (wr_state_q != BBAGC_WR_RESP);
    wire [ADDR_W-1:0] wr_addr = aw_take ? s_axi_awaddr : awaddr_q;
    wire [7:0] wr_byte = w_take ? s_axi_wdata[7:0] : wdata_q;
    wire wr_lane0 = w_take ? s_axi_wstrb[0] : wstrb0_q;
    wire [5:0] wr_idx = wr_addr[7:2];
    wire wr_hit = (wr_idx >= IDX_CW_SCALE_LOCKIN) &&
        (wr_idx <= IDX_LAST) && !wr_idx[0];
    wire [5:0] wr_off = wr_idx - IDX_CW_SCALE_LOCKIN;
    wire [3:0] wr_slot = wr_off[4:1];

    assign s_axi_awready = (wr_state_q == BBAGC_WR_IDLE) ||
        (wr_state_q == BBAGC_WR_DATA);
    assign s_axi_wready = (wr_state_q == BBAGC_WR_IDLE) ||
        (wr_state_q == BBAGC_WR_ADDR);
    assign s_axi_bvalid = (wr_state_q == BBAGC_WR_RESP);
    assign s_axi_bresp = bresp_q;

    always_comb begin
        wr_state_d = wr_state_q;
        case (wr_state_q)
            BBAGC_WR_IDLE: begin
                if (aw_take && w_take) begin
                    wr_state_d = BBAGC_WR_RESP;
                end else if (aw_take) begin
                    wr_state_d = BBAGC_WR_ADDR;
                end else if (w_take) begin
                    wr_state_d = BBAGC_WR_DATA;
                end
            end
            BBAGC_WR_ADDR: begin
                if (w_take) begin
                    wr_state_d = BBAGC_WR_RESP;
                end
            end
            BBAGC_WR_DATA: begin
                if (aw_take) begin
                    wr_state_d = BBAGC_WR_RESP;
                end
            end
            BBAGC_WR_RESP: begin
                if (s_axi_bready) begin
                    wr_state_d = BBAGC_WR_IDLE;
                end
            end
            default: wr_state_d = BBAGC_WR_IDLE;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wr_state_q <= BBAGC_WR_IDLE;
            awaddr_q <= '0;
            wdata_q <= REG_RESET;
            wstrb0_q <= 1'b0;
            bresp_q <= RESP_OKAY;
        end else begin
            wr_state_q <= wr_state_d;
            if (aw_take) begin
                awaddr_q <= s_axi_awaddr;
            end
            if (w_take) begin
                wdata_q <= s_axi_wdata[7:0];
                wstrb0_q <= s_axi_wstrb[0];
            end
            if (wr_commit) begin
                bresp_q <= wr_hit ? RESP_OKAY : RESP_SLVERR;
            end
        end
    end

    // ------------------------------------------------------------------
    // Register bank, all bits kept as written
    // ------------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < NUM_REGS; gi++) begin : g_reg
            wire we = wr_commit && wr_hit && wr_lane0 &&
                (wr_slot == 4'(gi));
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    regs_q[gi] <= REG_RESET;
                end else if (we) begin
                    regs_q[gi] <= wr_byte;
                end
            end
        end
    endgenerate

    // Writing table data also loads the entry at the table address
    wire tbl_we = wr_commit && wr_hit && wr_lane0 &&
        (wr_slot == SLOT_TABLE_DATA);
    wire [4:0] tbl_addr = regs_q[SLOT_TABLE_ADDR][4:0];
    always_ff @(posedge aclk) begin
        if (tbl_we) begin
            table_q[tbl_addr] <= wr_byte[6:0];
        end
    end

    // ------------------------------------------------------------------
    // Read channel
    // ------------------------------------------------------------------
    wire ar_take = s_axi_arvalid && s_axi_arready;
    wire [5:0] rd_idx = s_axi_araddr[7:2];
    wire rd_hit = (rd_idx >= IDX_CW_SCALE_LOCKIN) &&
        (rd_idx <= IDX_LAST) && !rd_idx[0];
    wire [5:0] rd_off = rd_idx - IDX_CW_SCALE_LOCKIN;
    wire [3:0] rd_slot = rd_off[4:1];
    wire rd_tbl_sel = regs_q[SLOT_TABLE_ADDR][TADDR_RD_SEL_BIT];
    wire [7:0] rd_reg = regs_q[rd_slot];
    wire [7:0] rd_tbl = {1'b0, table_q[tbl_addr]};
    wire [7:0] rd_byte = !rd_hit ? 8'h00 :
        ((rd_slot == SLOT_TABLE_DATA) && rd_tbl_sel) ? rd_tbl :
        rd_reg;

    assign s_axi_arready = !rvalid_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rdata_q <= '0;
            rresp_q <= RESP_OKAY;
        end else if (ar_take) begin
            rvalid_q <= 1'b1;
            rdata_q <= {24'h000000, rd_byte};
            rresp_q <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Field decode
    // ------------------------------------------------------------------
    wire [7:0] r_cw = regs_q[0];
    wire [7:0] r_pos = regs_q[1];
    wire [7:0] r_test = regs_q[7];
    wire [7:0] r_ovr = regs_q[6];
    wire [7:0] r_thr = regs_q[8];
    wire [7:0] r_sat = regs_q[9];
    wire [7:0] r_neg = regs_q[10];

    wire ovr_en = r_test[TEST_OVR_EN_BIT];
    wire rf_thr_low = !r_thr[RF_THR_DIS_BIT] &&
        (agc_voltage < r_thr[6:0]);
    wire rf_loop = loop_rf_pad_remove || rf_thr_low;
    wire rf_pre = ovr_en ? r_ovr[OVR_RF_BIT] : rf_loop;
    wire rf_d = rf_pre ^ r_test[TEST_POL_BIT];
    wire [6:0] if_d = ovr_en ? r_ovr[6:0] : loop_if_gain;
    wire search_d = agc_updates_to_lock <= {5'h00, r_pos[7:5]};
    wire upd_d = r_test[TEST_CONT_BIT] ||
        !(agc_freeze || agc_locked);
    wire [5:0] block_lvl = SAT_BLOCK_BASE + {3'h0, r_neg[7:5]};
    wire sat_ok = r_test[TEST_SATSTEP_BIT] &&
        (agc_level_halfdb > block_lvl);
    wire [4:0] mid_d = (sat_ok && iq_sat_count > mid_sat_threshold) ?
        {r_sat[7:4], 1'b0} : 5'h00;
    wire [3:0] low_d = (sat_ok && iq_sat_count > low_sat_threshold) ?
        r_sat[3:0] : 4'h0;
    wire [5:0] neg_d = 6'h00 - {1'b0, r_neg[4:0]};

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cw_scale_q <= 3'h0;
            cw_on_q <= 1'b0;
            cw_off_q <= 1'b0;
            inner_q <= 5'h00;
            outer_pos_q <= 5'h00;
            outer_neg_q <= 6'h00;
            backoff_q <= 6'h00;
            coef_q <= 7'h00;
            cs2_q <= 6'h00;
            search_q <= 1'b0;
            upd_q <= 1'b0;
            extra_q <= 1'b0;
            abort_q <= 1'b0;
            mid_q <= 5'h00;
            low_q <= 4'h0;
            rf_q <= 1'b0;
            if_gain_q <= 7'h00;
        end else begin
            cw_scale_q <= r_cw[7:5];
            cw_on_q <= (r_cw[7:5] == CW_FORCE_ON);
            cw_off_q <= (r_cw[7:5] == CW_FORCE_OFF);
            inner_q <= r_cw[4:0];
            outer_pos_q <= r_pos[4:0];
            outer_neg_q <= neg_d;
            backoff_q <= regs_q[2][5:0];
            coef_q <= regs_q[5][6:0];
            cs2_q <= regs_q[11][5:0];
            search_q <= search_d;
            upd_q <= upd_d;
            extra_q <= !r_test[TEST_EXTRA_DIS_BIT];
            abort_q <= r_test[TEST_ABORT2_BIT] &&
                second_ant_power_lower;
            mid_q <= mid_d;
            low_q <= low_d;
            rf_q <= rf_d;
            if_gain_q <= if_d;
        end
    end

    // ------------------------------------------------------------------
    // Transmit power, applied on the enable's rising edge
    // ------------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            transmit_path_enable_meta_q <= 1'b0;
            transmit_path_enable_sync_q <= 1'b0;
            transmit_path_enable_prev_q <= 1'b0;
            tx_power_q <= 7'h00;
        end else begin
            transmit_path_enable_meta_q <= transmit_path_enable;
            transmit_path_enable_sync_q <= transmit_path_enable_meta_q;
            transmit_path_enable_prev_q <= transmit_path_enable_sync_q;
            if (transmit_path_enable_sync_q && !transmit_path_enable_prev_q) begin
                tx_power_q <= regs_q[12][7:1];
            end
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign cw_scale = cw_scale_q;
    assign cw_force_active = cw_on_q;
    assign cw_force_inactive = cw_off_q;
    assign inner_lock_window = inner_q;
    assign antenna_search_allow = search_q;
    assign outer_window_pos = outer_pos_q;
    assign outer_window_neg = outer_neg_q;
    assign adc_backoff = backoff_q;
    assign loop_coefficient = coef_q;
    assign gain_update_allow = upd_q;
    assign extra_update_enable = extra_q;
    assign abort_second_antenna = abort_q;
    assign sat_atten_mid = mid_q;
    assign sat_atten_low = low_q;
    assign second_carrier_sense = cs2_q;
    assign rf_gain_step_line = rf_q;
    assign if_gain_line = if_gain_q;
    assign tx_power_dac = tx_power_q;
endmodule : bbagc_config_regs

// ---- bbagc_pkg.sv ----
// Constants for the receive gain configuration register bank
package bbagc_pkg;
    // ------------------------------------------------------------------
    // Bus geometry
    // ------------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int NUM_REGS = 13;
    localparam int TABLE_DEPTH = 32;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ------------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ------------------------------------------------------------------
    localparam logic [5:0] IDX_CW_SCALE_LOCKIN = 6'h26;
    localparam logic [5:0] IDX_LOCK_WIN_POS = 6'h28;
    localparam logic [5:0] IDX_GAIN_BACKOFF = 6'h2A;
    localparam logic [5:0] IDX_TABLE_ADDR = 6'h2C;
    localparam logic [5:0] IDX_TABLE_DATA = 6'h2E;
    localparam logic [5:0] IDX_LOOP_COEF = 6'h30;
    localparam logic [5:0] IDX_OVERRIDE_VALS = 6'h32;
    localparam logic [5:0] IDX_TEST_CTRL = 6'h34;
    localparam logic [5:0] IDX_RF_PAD_THRESH = 6'h36;
    localparam logic [5:0] IDX_SAT_ATTEN = 6'h38;
    localparam logic [5:0] IDX_LOCK_WIN_NEG = 6'h3A;
    localparam logic [5:0] IDX_CS_SCALE = 6'h3C;
    localparam logic [5:0] IDX_TX_POWER = 6'h3E;
    localparam logic [5:0] IDX_LAST = IDX_TX_POWER;
    // Slot within the bank
    localparam logic [3:0] SLOT_TABLE_ADDR = 4'h3;
    localparam logic [3:0] SLOT_TABLE_DATA = 4'h4;

    // ------------------------------------------------------------------
    // Field positions and values
    // ------------------------------------------------------------------
    localparam int TADDR_RD_SEL_BIT = 5;
    localparam int TEST_CONT_BIT = 7;
    localparam int TEST_POL_BIT = 6;
    localparam int TEST_EXTRA_DIS_BIT = 5;
    localparam int TEST_OVR_EN_BIT = 2;
    localparam int TEST_ABORT2_BIT = 1;
    localparam int TEST_SATSTEP_BIT = 0;
    localparam int OVR_RF_BIT = 7;
    localparam int RF_THR_DIS_BIT = 7;
    localparam logic [2:0] CW_FORCE_ON = 3'h0;
    localparam logic [2:0] CW_FORCE_OFF = 3'h7;
    // Block level is 4.0 dB plus half steps, counted in half dB
    localparam logic [5:0] SAT_BLOCK_BASE = 6'h08;
    localparam logic [7:0] REG_RESET = 8'h00;

    // ------------------------------------------------------------------
    // Write channel states
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        BBAGC_WR_IDLE = 2'b00,
        BBAGC_WR_ADDR = 2'b01,
        BBAGC_WR_RESP = 2'b11,
        BBAGC_WR_DATA = 2'b10
    } bbagc_wr_state_t;
endpackage : bbagc_pkg

// ---- bbagc_config_regs_properties.sv ----
// Concurrent checks on the ports of the gain configuration bank
`timescale 1ns/1ns
module bbagc_config_regs_properties (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [7:0] agc_updates_to_lock,
    input wire logic agc_freeze,
    input wire logic agc_locked,
    input wire logic second_ant_power_lower,
    input wire logic [5:0] agc_level_halfdb,
    input wire logic [3:0] iq_sat_count,
    input wire logic [3:0] mid_sat_threshold,
    input wire logic [3:0] low_sat_threshold,
    input wire logic transmit_path_enable,
    input wire logic [2:0] cw_scale,
    input wire logic cw_force_active,
    input wire logic cw_force_inactive,
    input wire logic antenna_search_allow,
    input wire logic signed [5:0] outer_window_neg,
    input wire logic gain_update_allow,
    input wire logic abort_second_antenna,
    input wire logic [4:0] sat_atten_mid,
    input wire logic [3:0] sat_atten_low,
    input wire logic signed [6:0] tx_power_dac
);
    // ------------------------------------------------------------------
    // Bus handshake
    // ------------------------------------------------------------------
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    sequence s_rd_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    sequence s_rd_answer;
        s_axi_rvalid && !s_axi_arready && s_axi_rdata[31:8] == 24'h000000;
    endsequence
    property p_rd_resp;
        s_rd_taken |=> s_rd_answer;
    endproperty
    a_rd_resp: assert property (p_rd_resp)
        else $error("read answer missing or malformed");
    property p_bhold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
    endproperty
    a_bhold: assert property (p_bhold)
        else $error("write response dropped early");

    // ------------------------------------------------------------------
    // Decoded controls
    // ------------------------------------------------------------------
    property p_cw;
        $past(aresetn, 2) |-> cw_force_active == (cw_scale == 3'h0)
            && cw_force_inactive == (cw_scale == 3'h7);
    endproperty
    a_cw: assert property (p_cw)
        else $error("cw force flags disagree with scale");
    property p_search;
        antenna_search_allow |-> $past(agc_updates_to_lock) <= 8'h07;
    endproperty
    a_search: assert property (p_search)
        else $error("antenna search allowed above max count");
    property p_neg;
        outer_window_neg <= 0;
    endproperty
    a_neg: assert property (p_neg)
        else $error("negative window side not negated");
    property p_upd;
        !gain_update_allow && $past(aresetn, 2)
            |-> $past(agc_freeze || agc_locked);
    endproperty
    a_upd: assert property (p_upd)
        else $error("updates stopped while not frozen");
    property p_abort;
        abort_second_antenna |-> $past(second_ant_power_lower);
    endproperty
    a_abort: assert property (p_abort)
        else $error("abort without weaker second antenna");
    property p_mid;
        sat_atten_mid != 5'h00 |-> !sat_atten_mid[0] && $past(iq_sat_count
            > mid_sat_threshold && agc_level_halfdb > 6'h08);
    endproperty
    a_mid: assert property (p_mid)
        else $error("mid attenuation without cause");
    property p_low;
        sat_atten_low != 4'h0 |-> $past(iq_sat_count > low_sat_threshold
            && agc_level_halfdb > 6'h08);
    endproperty
    a_low: assert property (p_low)
        else $error("low attenuation without cause");
    property p_tx;
        $changed(tx_power_dac) |-> $past(transmit_path_enable, 3)
            && !$past(transmit_path_enable, 4);
    endproperty
    a_tx: assert property (p_tx)
        else $error("power value moved without enable rise");
endmodule : bbagc_config_regs_properties

// ---- tb_top.sv ----
// Self-checking bench for the gain configuration bank
`timescale 1ns/1ns
module tb_top
    import bbagc_pkg::*;
;
    typedef struct {
        logic [7:0] a;
        logic [7:0] d;
        int s;
        logic [11:0] e;
    } bbagc_row_t;
    logic aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0;
    logic s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [7:0] agc_updates_to_lock = 8'h07;
    logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
    logic [31:0] s_axi_wdata = 32'h00000000;
    logic [3:0] s_axi_wstrb = 4'hF, iq_sat_count = 4'h5;
    logic [3:0] mid_sat_threshold = 4'h4, low_sat_threshold = 4'h4;
    logic agc_freeze = 1'b1, agc_locked = 1'b0;
    logic second_ant_power_lower = 1'b1, loop_rf_pad_remove = 1'b0;
    logic transmit_path_enable = 1'b0;
    logic [6:0] agc_voltage = 7'h10, loop_if_gain = 7'h11;
    logic [5:0] agc_level_halfdb = 6'h0C;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, cw_force_active, cw_force_inactive;
    logic antenna_search_allow, gain_update_allow, extra_update_enable;
    logic abort_second_antenna, rf_gain_step_line;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic [2:0] cw_scale;
    logic [4:0] inner_lock_window, outer_window_pos, sat_atten_mid;
    logic [3:0] sat_atten_low;
    logic [5:0] adc_backoff, second_carrier_sense;
    logic [6:0] loop_coefficient, if_gain_line;
    logic signed [5:0] outer_window_neg;
    logic signed [6:0] tx_power_dac;
    int errors = 0;
    int n_compared = 0;
    bbagc_row_t rows [19] = '{
        '{8'h98, 8'h00, 0, 12'h200},
        '{8'h98, 8'hFF, 0, 12'h1FF},
        '{8'h98, 8'h55, 0, 12'h055},
        '{8'hA0, 8'hFF, 1, 12'h03F},
        '{8'hA0, 8'hC5, 1, 12'h005},
        '{8'hA8, 8'hFF, 2, 12'h03F},
        '{8'hC0, 8'h5A, 3, 12'h05A},
        '{8'hF0, 8'hFF, 4, 12'h03F},
        '{8'hE8, 8'h1F, 5, 12'h021},
        '{8'hE8, 8'h01, 5, 12'h03F},
        '{8'hD8, 8'h20, 6, 12'h223},
        '{8'hD8, 8'hA0, 6, 12'h222},
        '{8'hD0, 8'hE0, 6, 12'h423},
        '{8'hC8, 8'hAB, 6, 12'h423},
        '{8'hD0, 8'h06, 6, 12'h357},
        '{8'hC8, 8'h2B, 6, 12'h356},
        '{8'hD0, 8'h46, 6, 12'h357},
        '{8'hE0, 8'hF9, 7, 12'h000},
        '{8'hD0, 8'h01, 7, 12'h1E9}
    };

    bbagc_config_regs dut_u (.*);

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [11:0] obs(input int s);
        case (s)
            0: obs = {2'h0, cw_force_active, cw_force_inactive, cw_scale,
                      inner_lock_window};
            1: obs = {6'h00, antenna_search_allow, outer_window_pos};
            2: obs = {6'h00, adc_backoff};
            3: obs = {5'h00, loop_coefficient};
            4: obs = {6'h00, second_carrier_sense};
            5: obs = {6'h00, outer_window_neg};
            6: obs = {1'h0, gain_update_allow, extra_update_enable,
                      abort_second_antenna, if_gain_line, rf_gain_step_line};
            default: obs = {3'h0, sat_atten_mid, sat_atten_low};
        endcase
    endfunction : obs

    task automatic check(input string nm, input logic [31:0] seen,
                         input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    task automatic tick(input int n);
        repeat (n) @(posedge aclk);
        #1;
    endtask : tick

    task automatic axi_write(input logic [7:0] a, input logic [7:0] d,
                             input logic [3:0] st, input logic [1:0] r);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h000000, d};
        s_axi_wstrb <= st;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            // Late accept keeps the response waiting one cycle
            s_axi_bready <= s_axi_bvalid && !s_axi_bready;
        end while (!(s_axi_bvalid === 1'b1 && s_axi_bready));
        check("bresp", 32'(s_axi_bresp), 32'(r));
    endtask : axi_write

    task automatic axi_read(input logic [7:0] a, input logic [7:0] e,
                            input logic [1:0] r);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
        check("rdata", s_axi_rdata, {24'h000000, e});
        check("rresp", 32'(s_axi_rresp), 32'(r));
    endtask : axi_read

    task automatic end_of_test;
        $display("compared %0d errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : end_of_test

    // ------------------------------------------------------------------
    // Clock, watchdog and sequence
    // ------------------------------------------------------------------
    initial begin
        forever #10 aclk = ~aclk;
    end

    initial begin
        repeat (20000) @(posedge aclk);
        errors++;
        end_of_test();
    end

    initial begin
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        for (int i = 0; i < 13; i++) begin
            axi_read(8'h98 + 8'(i * 8), 8'h00, RESP_OKAY);
        end
        for (int i = 0; i < 19; i++) begin
            axi_write(rows[i].a, rows[i].d, 4'hF, RESP_OKAY);
            axi_read(rows[i].a, rows[i].d, RESP_OKAY);
            tick(2);
            check("out", 32'(obs(rows[i].s)), 32'(rows[i].e));
        end
        @(posedge aclk);
        agc_updates_to_lock <= 8'h06;
        agc_freeze <= 1'b0;
        agc_locked <= 1'b1;
        loop_rf_pad_remove <= 1'b1;
        tick(3);
        check("search", 32'(antenna_search_allow), 32'h1);
        check("out", 32'(obs(6)), 32'h223);
        @(posedge aclk);
        agc_locked <= 1'b0;
        agc_level_halfdb <= 6'h08;
        tick(3);
        check("out", 32'(obs(6)), 32'h623);
        check("sat", 32'(obs(7)), 32'h000);
        @(posedge aclk);
        agc_level_halfdb <= 6'h09;
        low_sat_threshold <= 4'h5;
        tick(3);
        check("sat", 32'(obs(7)), 32'h1E0);
        axi_write(8'hB0, 8'h05, 4'hF, RESP_OKAY);
        axi_write(8'hB8, 8'hFF, 4'hF, RESP_OKAY);
        axi_write(8'hB0, 8'h06, 4'hF, RESP_OKAY);
        axi_write(8'hB8, 8'h12, 4'hF, RESP_OKAY);
        axi_read(8'hB8, 8'h12, RESP_OKAY);
        axi_write(8'hB0, 8'h25, 4'hF, RESP_OKAY);
        axi_read(8'hB8, 8'h7F, RESP_OKAY);
        axi_write(8'hB0, 8'h26, 4'hF, RESP_OKAY);
        axi_read(8'hB8, 8'h12, RESP_OKAY);
        axi_write(8'h00, 8'h55, 4'hF, RESP_SLVERR);
        axi_read(8'h9C, 8'h00, RESP_SLVERR);
        axi_read(8'hFC, 8'h00, RESP_SLVERR);
        axi_write(8'h98, 8'hAA, 4'h0, RESP_OKAY);
        axi_read(8'h98, 8'h55, RESP_OKAY);
        axi_write(8'hF8, 8'h82, 4'hF, RESP_OKAY);
        tick(5);
        check("txdac", {25'h0, tx_power_dac}, 32'h00);
        @(posedge aclk);
        transmit_path_enable <= 1'b1;
        tick(5);
        check("txdac", {25'h0, tx_power_dac}, 32'h41);
        axi_write(8'hF8, 8'h7E, 4'hF, RESP_OKAY);
        tick(5);
        check("txdac", {25'h0, tx_power_dac}, 32'h41);
        @(posedge aclk);
        transmit_path_enable <= 1'b0;
        tick(4);
        @(posedge aclk);
        transmit_path_enable <= 1'b1;
        tick(5);
        check("txdac", {25'h0, tx_power_dac}, 32'h3F);
        @(posedge aclk);
        transmit_path_enable <= 1'b0;
        aresetn <= 1'b0;
        tick(3);
        @(posedge aclk);
        aresetn <= 1'b1;
        axi_read(8'h98, 8'h00, RESP_OKAY);
        check("txdac", {25'h0, tx_power_dac}, 32'h00);
        end_of_test();
    end
endmodule : tb_top

bind bbagc_config_regs bbagc_config_regs_properties chk_u (.*);
